//--- rtl/pp_defs.svh
// constants of the port 0 / port 1 block: offsets, reset values, bit slots
// assumes inclusion by bare name from the main module
`ifndef PP_DEFS_SVH
`define PP_DEFS_SVH
`define PP_SFR_LO       16'h0000
`define PP_SFR_HI       16'h003f
`define PP_OFF_P0_LATCH 16'h0000
`define PP_OFF_P1_LATCH 16'h0001
`define PP_OFF_P0_PINS  16'h0008
`define PP_OFF_P1_DIR   16'h000d
`define PP_P0_LATCH_RST 8'hff
`define PP_P1_LATCH_RST 8'h00
`define PP_P1_DIR_RST   8'h00
`define PP_IRQ0_BIT     0
`define PP_IDLE_BYTE    8'h00
`endif

//--- rtl/pp_pkg.sv
// types shared by the port 0 / port 1 block
// assumes nothing beyond the constants header
package pp_pkg;
	typedef logic [7:0] pp_byte_t;
	typedef enum logic [2:0] {
		PP_SEL_NONE,
		PP_SEL_P0_LATCH,
		PP_SEL_P1_LATCH,
		PP_SEL_P0_PINS,
		PP_SEL_P1_DIR
	} pp_sel_t;
endpackage

//--- rtl/pp_port.sv
// parallel port 0 and port 1 logic behind the special-function space
// assumes the cpu marks the first and second execution states with pulses
// Function
// - decode the whole special-function space from 0000h to 003fh
// - outputs latched per port, inputs unlatched, so sources hold data
// - pin levels are sampled in the first execution state of a read
// - output data changes in the second execution state of a write
// - reset sets all port 0 latch bits to one
// - port 0 latch address reads latch, pin address reads pins
// - port 0 bit 0 is port or interrupt input, port after reset
// - port 0 pins shared with interrupt, serial and timer signals
// - port 1 bit is input when direction is 0, output when 1
// - reset clears port 1 direction and port 1 latch
// - port 1 pins shared with interrupt, timer and divider functions
// - port 1 latch writes are taken whatever the direction
// - port 1 reads pins for inputs and latch for outputs
// - irq0 select 0 gives port, 1 gives interrupt with pin as input
`include "pp_defs.svh"
module pp_port (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] cpuAddr,
	input  wire logic        cpuRd,
	input  wire logic        cpuWr,
	input  wire logic        firstExecState,
	input  wire logic        secondExecState,
	input  wire logic [7:0]  cpuWdata,
	output logic      [7:0]  cpuRdata,
	output logic             cpuRdValid,
	output logic             sfrHit,
	output logic             portHit,
	input  wire logic        irq0PinSelect,
	input  wire logic [7:0]  p0AltOut,
	input  wire logic [7:0]  p0PinIn,
	output logic      [7:0]  p0PinOut,
	output logic      [7:0]  p0PinOe,
	output logic      [7:0]  p0AltIn,
	output logic             extIrqZeroN,
	input  wire logic [7:0]  p1AltOut,
	input  wire logic [7:0]  p1PinIn,
	output logic      [7:0]  p1PinOut,
	output logic      [7:0]  p1PinOe,
	output logic      [7:0]  p1AltIn
);
	pp_pkg::pp_byte_t p0Latch_q;
	pp_pkg::pp_byte_t p1Latch_q;
	pp_pkg::pp_byte_t p1Dir_q;
	pp_pkg::pp_byte_t rdata_q;
	logic             rdValid_q;
	pp_pkg::pp_byte_t p0Pins;
	pp_pkg::pp_byte_t p1Pins;
	pp_pkg::pp_byte_t p1Readback;
	pp_pkg::pp_byte_t rdMux;
	pp_pkg::pp_sel_t  regSel;
	logic             rdTake;
	logic             wrTake;

	function automatic logic offHit(input logic [15:0] a,
		input logic [15:0] off);
		offHit = (a == off);
	endfunction

	pp_sync u_sync0 (
		.clk  (clk),
		.nrst (nrst),
		.din  (p0PinIn),
		.dout (p0Pins)
	);

	pp_sync u_sync1 (
		.clk  (clk),
		.nrst (nrst),
		.din  (p1PinIn),
		.dout (p1Pins)
	);

	// window decode
	assign sfrHit = (cpuAddr >= `PP_SFR_LO) && (cpuAddr <= `PP_SFR_HI);
	assign regSel =
		offHit(cpuAddr, `PP_OFF_P0_LATCH) ? pp_pkg::PP_SEL_P0_LATCH :
		offHit(cpuAddr, `PP_OFF_P1_LATCH) ? pp_pkg::PP_SEL_P1_LATCH :
		offHit(cpuAddr, `PP_OFF_P0_PINS)  ? pp_pkg::PP_SEL_P0_PINS  :
		offHit(cpuAddr, `PP_OFF_P1_DIR)   ? pp_pkg::PP_SEL_P1_DIR   :
		pp_pkg::PP_SEL_NONE;
	assign portHit = sfrHit && (regSel != pp_pkg::PP_SEL_NONE);
	assign rdTake  = cpuRd && firstExecState && portHit;
	assign wrTake  = cpuWr && secondExecState && portHit;

	// port 1 readback per bit
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_p1rd
			assign p1Readback[i] = p1Dir_q[i] ? p1Latch_q[i] : p1Pins[i];
		end
	endgenerate

	always_comb begin
		case (regSel)
			pp_pkg::PP_SEL_P0_LATCH: rdMux = p0Latch_q;
			pp_pkg::PP_SEL_P1_LATCH: rdMux = p1Readback;
			pp_pkg::PP_SEL_P0_PINS:  rdMux = p0Pins;
			pp_pkg::PP_SEL_P1_DIR:   rdMux = p1Dir_q;
			default:                 rdMux = `PP_IDLE_BYTE;
		endcase
	end

	// read sampling, pins caught at the first execution state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q   <= `PP_IDLE_BYTE;
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= rdTake;
			if (rdTake) begin
				rdata_q <= rdMux;
			end
		end
	end

	// output latches and direction
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			p0Latch_q <= `PP_P0_LATCH_RST;
			p1Latch_q <= `PP_P1_LATCH_RST;
			p1Dir_q   <= `PP_P1_DIR_RST;
		end else if (wrTake) begin
			case (regSel)
				pp_pkg::PP_SEL_P0_LATCH: p0Latch_q <= cpuWdata;
				pp_pkg::PP_SEL_P1_LATCH: p1Latch_q <= cpuWdata;
				pp_pkg::PP_SEL_P1_DIR:   p1Dir_q   <= cpuWdata;
				default: ;
			endcase
		end
	end

	assign cpuRdata   = rdata_q;
	assign cpuRdValid = rdValid_q;

	// port 0: pulls low where latch or alternate output is zero, except bit 0 while irq0 is selected
	pp_pkg::pp_byte_t p0Drive;
	assign p0Drive = p0Latch_q & p0AltOut;
	generate
		for (i = 0; i < 8; i++) begin : g_p0pin
			if (i == `PP_IRQ0_BIT) begin : g_irq
				assign p0PinOe[i] = ~irq0PinSelect & ~p0Drive[i];
			end else begin : g_plain
				assign p0PinOe[i] = ~p0Drive[i];
			end
		end
	endgenerate
	assign p0PinOut    = 8'h00;
	assign p0AltIn     = p0Pins;
	assign extIrqZeroN = irq0PinSelect ? p0Pins[`PP_IRQ0_BIT] : 1'b1;

	// port 1: push-pull per direction bit
	assign p1PinOut = p1Latch_q & p1AltOut;
	assign p1PinOe  = p1Dir_q;
	assign p1AltIn  = p1Pins;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_rd_sample_pins: assert property (
		rdTake && regSel == pp_pkg::PP_SEL_P0_PINS
		|=> cpuRdValid && cpuRdata == $past(p0Pins))
		else $error("pin read not sampled in first state");
	a_rd_latch_p0: assert property (
		rdTake && regSel == pp_pkg::PP_SEL_P0_LATCH
		|=> cpuRdata == $past(p0Latch_q))
		else $error("port 0 latch read wrong");
	a_wr_second_state: assert property (
		cpuWr && secondExecState && regSel == pp_pkg::PP_SEL_P0_LATCH
		|=> p0Latch_q == $past(cpuWdata))
		else $error("port 0 write not taken in second state");
	a_latch_hold_nowr: assert property (
		!wrTake |=> $stable(p0Latch_q) && $stable(p1Latch_q)
		&& $stable(p1Dir_q))
		else $error("register changed without a write");
	a_p1_dir_oe: assert property (
		p1PinOe == p1Dir_q && (p1PinOut & ~p1Latch_q) == 8'h00)
		else $error("port 1 direction not honoured");
	a_p1_wr_any_dir: assert property (
		wrTake && regSel == pp_pkg::PP_SEL_P1_LATCH
		|=> p1Latch_q == $past(cpuWdata))
		else $error("port 1 latch write refused");
	a_p1_readback: assert property (
		rdTake && regSel == pp_pkg::PP_SEL_P1_LATCH
		|=> cpuRdata == (($past(p1Dir_q) & $past(p1Latch_q))
		| (~$past(p1Dir_q) & $past(p1Pins))))
		else $error("port 1 mixed readback wrong");
	a_irq0_pin_input: assert property (
		irq0PinSelect |-> !p0PinOe[0]
		&& extIrqZeroN == p0Pins[0])
		else $error("irq0 pin not left as input");
	a_irq0_idle: assert property (
		!irq0PinSelect |-> extIrqZeroN)
		else $error("irq0 active while pin is port");
	a_window_hit: assert property (
		cpuRd && firstExecState && !portHit |=> !cpuRdValid)
		else $error("read answered outside port registers");
	a_rd_valid_pulse: assert property (
		cpuRdValid |-> $past(rdTake))
		else $error("read answer without a taken read");
	a_reset_values: assert property (
		$rose(nrst) |-> p0Latch_q == `PP_P0_LATCH_RST
		&& p1Latch_q == `PP_P1_LATCH_RST
		&& p1Dir_q == `PP_P1_DIR_RST)
		else $error("reset values wrong");

	c_p0_write: cover property (wrTake
		&& regSel == pp_pkg::PP_SEL_P0_LATCH);
	c_p1_mixed: cover property (rdTake
		&& regSel == pp_pkg::PP_SEL_P1_LATCH && p1Dir_q != 8'h00
		&& p1Dir_q != 8'hff);
	c_irq0_use: cover property (irq0PinSelect && !extIrqZeroN);
	c_pin_read: cover property (rdTake
		&& regSel == pp_pkg::PP_SEL_P0_PINS);
	c_foreign_read: cover property (cpuRd && firstExecState
		&& sfrHit && !portHit);
endmodule // pp_port

//--- rtl/pp_sync.sv
// two flip-flop synchroniser for a byte of pin levels
// assumes pins are asynchronous to clk
module pp_sync (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [7:0] din,
	output logic      [7:0] dout
);
	logic [7:0] meta_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 8'h00;
			dout   <= 8'h00;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule // pp_sync

//--- tb/pp_board.sv
// board model: pull-ups on port 0, outside drivers on both ports
// assumes the bench sets the outside levels ext0 and ext1
module pp_board (
	input  wire logic [7:0] p0PinOe,
	input  wire logic [7:0] p1PinOut,
	input  wire logic [7:0] p1PinOe,
	input  wire logic [7:0] ext0,
	input  wire logic [7:0] ext1,
	output logic      [7:0] p0PinIn,
	output logic      [7:0] p1PinIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// open drain with pull-up: low if either side pulls
	assign p0PinIn = ~p0PinOe & ext0;
	// driven bits follow p1PinOut, the rest follow the board
	assign p1PinIn = (p1PinOe & p1PinOut) | (~p1PinOe & ext1);
endmodule // pp_board

//--- tb/tb.sv
// bench for the port 0 / port 1 block
// assumes pp_board stands for the pins
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, nrst = 0, cpuRd = 0, cpuWr = 0;
	logic        firstExecState = 0, secondExecState = 0;
	logic        irq0PinSelect = 0, cpuRdValid, sfrHit, portHit;
	logic        extIrqZeroN;
	logic [15:0] cpuAddr = 16'h0000;
	logic [7:0]  cpuWdata = 8'h00, ext0 = 8'hff, ext1 = 8'h00;
	logic [7:0]  p0AltOut = 8'hff, p1AltOut = 8'hff;
	logic [7:0]  cpuRdata, p0PinIn, p0PinOut, p0PinOe, p0AltIn;
	logic [7:0]  p1PinIn, p1PinOut, p1PinOe, p1AltIn, got;
	int          num_errors = 0, num_checks = 0;
	always #2.5 clk = ~clk;
	pp_port dut_u (.clk, .nrst, .cpuAddr, .cpuRd, .cpuWr,
		.firstExecState, .secondExecState, .cpuWdata, .cpuRdata,
		.cpuRdValid, .sfrHit, .portHit, .irq0PinSelect,
		.p0AltOut, .p0PinIn, .p0PinOut, .p0PinOe, .p0AltIn,
		.extIrqZeroN, .p1AltOut, .p1PinIn, .p1PinOut,
		.p1PinOe, .p1AltIn);
	pp_board board_u (.p0PinOe, .p1PinOut, .p1PinOe, .ext0, .ext1,
		.p0PinIn, .p1PinIn);
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d, input logic s);
		@(posedge clk);
		cpuAddr <= a;
		cpuWdata <= d;
		cpuWr <= 1'h1;
		secondExecState <= s;
		@(posedge clk);
		cpuWr <= 1'h0;
		secondExecState <= 1'h0;
		#1;
	endtask
	task rd(input logic [15:0] a, input logic v);
		@(posedge clk);
		cpuAddr <= a;
		cpuRd <= 1'h1;
		firstExecState <= 1'h1;
		@(posedge clk);
		cpuRd <= 1'h0;
		firstExecState <= 1'h0;
		#1;
		got = cpuRdata;
		chk("rdvalid", {7'h00, v}, {7'h00, cpuRdValid});
	endtask
	task t_reset;
		rd(16'h0000, 1'h1);
		chk("p0 latch", 8'hff, got);
		rd(16'h0001, 1'h1);
		chk("p1 latch", 8'h00, got);
		rd(16'h000d, 1'h1);
		chk("p1 dir", 8'h00, got);
		chk("p0 oe", 8'h00, p0PinOe);
		chk("p1 oe", 8'h00, p1PinOe);
		chk("p1 out", 8'h00, p1PinOut);
		chk("p0 out", 8'h00, p0PinOut);
		$display("test reset done");
	endtask
	task t_port0;
		wr(16'h0000, 8'ha5, 1'h1);
		chk("p0 oe", 8'h5a, p0PinOe);
		rd(16'h0000, 1'h1);
		chk("p0 latch", 8'ha5, got);
		ext0 <= 8'hf0;
		repeat (3) @(posedge clk);
		rd(16'h0008, 1'h1);
		chk("p0 pins", 8'ha0, got);
		chk("p0 alt in", 8'ha0, p0AltIn);
		@(posedge clk);
		p0AltOut <= 8'h7f;
		#1;
		chk("p0 oe alt", 8'hda, p0PinOe);
		@(posedge clk);
		p0AltOut <= 8'hff;
		$display("test port0 done");
	endtask
	task t_port1;
		wr(16'h0001, 8'h3c, 1'h1);
		chk("p1 out", 8'h3c, p1PinOut);
		chk("p1 oe", 8'h00, p1PinOe);
		wr(16'h0001, 8'hff, 1'h0);
		chk("no pulse", 8'h3c, p1PinOut);
		wr(16'h000d, 8'h0f, 1'h1);
		chk("p1 oe", 8'h0f, p1PinOe);
		ext1 <= 8'h55;
		repeat (3) @(posedge clk);
		rd(16'h0001, 1'h1);
		chk("p1 mixed", 8'h5c, got);
		chk("p1 alt in", 8'h5c, p1AltIn);
		@(posedge clk);
		p1AltOut <= 8'hf7;
		#1;
		chk("p1 out alt", 8'h34, p1PinOut);
		@(posedge clk);
		p1AltOut <= 8'hff;
		$display("test port1 done");
	endtask
	task t_irq0;
		@(posedge clk);
		irq0PinSelect <= 1'h1;
		wr(16'h0000, 8'h01, 1'h1);
		chk("p0 oe", 8'hfe, p0PinOe);
		ext0 <= 8'hfe;
		repeat (3) @(posedge clk);
		#1;
		chk("irq low", 8'h00, {7'h00, extIrqZeroN});
		@(posedge clk);
		ext0 <= 8'hff;
		repeat (3) @(posedge clk);
		#1;
		chk("irq high", 8'h01, {7'h00, extIrqZeroN});
		@(posedge clk);
		irq0PinSelect <= 1'h0;
		ext0 <= 8'hfe;
		repeat (3) @(posedge clk);
		#1;
		chk("irq off", 8'h01, {7'h00, extIrqZeroN});
		$display("test irq0 done");
	endtask
	task t_decode;
		rd(16'h0002, 1'h0);
		chk("hits", 8'h02, {6'h00, sfrHit, portHit});
		@(posedge clk);
		cpuAddr <= 16'h0040;
		#1;
		chk("hits", 8'h00, {6'h00, sfrHit, portHit});
		$display("test decode done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		t_reset();
		t_port0();
		t_port1();
		t_irq0();
		t_decode();
		summarize();
	end
endmodule // tb
